// File: bit_synchronizer.sv
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level; no bus coherence is promised
`timescale 1ns/1ps
module bit_synchronizer #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  if (W < 1)
  begin : g_chk
    $error("bit_synchronizer width must be at least one");
  end

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// File: discrete_peers.sv
// upstream sources feeding the discrete timer logic block
// assumes the bench sets wanted levels right after a clock edge
`timescale 1ns/1ps
module discrete_peers (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] want_value,
  input wire logic [3:0] want_defined,
  input wire logic want_reset,
  output logic [3:0] in_value,
  output logic [3:0] in_defined,
  output logic timer_reset_in
);
  logic toggle_ff;
  // ****
  // source lines
  // ****
  // changing pattern for lines without a defined value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) toggle_ff <= 1'b0;
    else toggle_ff <= ~toggle_ff;
  end
  // undefined lines never keep the last value
  assign in_value = (want_value & want_defined) | ({4{toggle_ff}} & ~want_defined);
  assign in_defined = want_defined;
  assign timer_reset_in = want_reset;
endmodule

// File: discrete_timer_logic.sv
// discrete timer logic: input combination, timer types, APB registers
// assumes an APB master on clk; input pins are asynchronous levels
//
// Contract
// - merge up to four inputs by the selected combination
// - OR, two-or-more, three-or-more and AND gate/vote settings
// - exact-count settings true only at exactly one, two or three
// - even parity true at 0, 2, 4; odd at 1, 3
// - undefined connected input gives bad status, not true or false
// - undefined operator-set unconnected input is left out
// - any input or the output may be inverted by configuration
// - each tick compares running interval against the setpoint, except in measure and accumulate types
// - in automatic mode the output copies the pre-output
// - elapsed output shows time spent in the current interval, or total on time for accumulate
// - quiescent only when not timing nor triggered; option picks outputs
// - measure/compare/delay idle while false; extend idle while true
// - accumulate ignores the idle option
// - debounce idle after change and expiry until next change
// - pulse types idle when false and expired until next rise
// - clear option zeroes outputs when idle; last option holds them
// - timer reset rise zeroes elapsed, reinitialises pre-output, remaining
// - start counter counts rises, restarts on timer reset
// - inputs inverted before use, output inverted after
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module discrete_timer_logic #(
  parameter int TIME_W = timer_logic_pkg::DEF_TIME_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] in_value,
  input wire logic [3:0] in_defined,
  input wire logic timer_reset_in,
  output logic out_d,
  output logic [TIME_W-1:0] elapsed_time_output,
  output logic [TIME_W-1:0] remaining_time_output,
  output logic bad_status
);
  import timer_logic_pkg::*;

  if (TIME_W < 8 || TIME_W > 31)
  begin : g_chk
    $error("TIME_W must lie between 8 and 31");
  end

  // ************************************************************
  // declarations
  // ************************************************************
  ctrl_s ctrl_ff, nxt_ctrl;
  in_cfg_s incfg_ff, nxt_incfg;
  logic [TIME_W-1:0] sp_ff, nxt_sp;
  logic [TICK_W-1:0] tlen_ff, nxt_tlen;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic sw_reset;

  logic [TICK_W-1:0] tick_cnt_ff, nxt_tick_cnt;
  logic prev_ff, nxt_prev;
  logic pre_ff, nxt_pre;
  logic [TIME_W-1:0] exp_ff, nxt_exp;
  logic [TIME_W-1:0] rem_ff, nxt_rem;
  logic [31:0] nstart_ff, nxt_nstart;
  logic out_ff, nxt_out;
  logic bad_ff, nxt_bad;
  logic quiet_ff, nxt_quiet;
  logic first_ff, nxt_first;
  logic rst_pend_ff, nxt_rst_pend;
  logic rst_prev_ff;

  logic [8:0] sync_q;
  logic pv;
  logic comb_bad;
  logic tick;
  logic [TICK_W-1:0] tlen;

  // ************************************************************
  // pin synchronisation and combination
  // ************************************************************
  bit_synchronizer #(.W(9)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({timer_reset_in, in_defined, in_value}),
    .q(sync_q)
  );

  input_combiner u_comb (
    .in_value(sync_q[3:0]),
    .in_defined(sync_q[7:4]),
    .cfg(incfg_ff),
    .sel(ctrl_ff.combination_select),
    .combined(pv),
    .bad(comb_bad)
  );

  // ************************************************************
  // APB slave
  // ************************************************************
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= OFF_START_COUNT);
  endfunction

  function automatic logic [31:0] widen(input logic [TIME_W-1:0] v);
    widen = {{(32 - TIME_W){1'b0}}, v};
  endfunction

  // next register values, read data and answer
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_incfg = incfg_ff;
    nxt_sp = sp_ff;
    nxt_tlen = tlen_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_pready = psel && penable && !pready_ff;
    sw_reset = 1'b0;
    if (nxt_pready)
    begin
      nxt_pslverr = !is_mapped(paddr);
      nxt_prdata = 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (paddr)
          OFF_CTRL: nxt_prdata = ctrl_ff;
          OFF_INPUT_CFG: nxt_prdata = incfg_ff;
          OFF_SETPOINT: nxt_prdata = widen(sp_ff);
          OFF_TICK_LEN: nxt_prdata = {{(32 - TICK_W){1'b0}}, tlen_ff};
          OFF_STATUS: nxt_prdata = {27'h0, quiet_ff, bad_ff, out_ff, pre_ff, pv};
          OFF_ELAPSED: nxt_prdata = widen(exp_ff);
          OFF_REMAINING: nxt_prdata = widen(rem_ff);
          OFF_START_COUNT: nxt_prdata = nstart_ff;
          default: nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
    // writes take effect at the edge that completes the access
    if (psel && penable && pready_ff && pwrite)
    begin
      unique case (paddr)
        OFF_CTRL:
        begin
          nxt_ctrl = ctrl_s'(pwdata);
          nxt_ctrl.rsvd = '0;
          nxt_ctrl.timer_reset = 1'b0;
          sw_reset = pwdata[1];
        end
        OFF_INPUT_CFG:
        begin
          nxt_incfg = in_cfg_s'(pwdata);
          nxt_incfg.rsvd = '0;
        end
        OFF_SETPOINT: nxt_sp = pwdata[TIME_W-1:0];
        OFF_TICK_LEN: nxt_tlen = pwdata[TICK_W-1:0];
        default: nxt_sp = sp_ff;
      endcase
    end
  end

  // bus register stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= ctrl_s'(RST_CTRL);
      incfg_ff <= in_cfg_s'(RST_INPUT_CFG);
      sp_ff <= RST_SETPOINT[TIME_W-1:0];
      tlen_ff <= RST_TICK_LEN;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      incfg_ff <= nxt_incfg;
      sp_ff <= nxt_sp;
      tlen_ff <= nxt_tlen;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ************************************************************
  // execution tick and timer
  // ************************************************************
  assign tlen = (tlen_ff == '0) ? TICK_W'(1) : tlen_ff;
  assign tick = tick_cnt_ff >= tlen - TICK_W'(1);

  function automatic logic [TIME_W-1:0] inc(input logic [TIME_W-1:0] v);
    inc = (&v) ? v : v + 1'b1; // saturates
  endfunction

  // per-tick timer evaluation
  always_comb
  begin
    logic rise;
    logic fall;
    logic q;
    logic [TIME_W-1:0] e;
    logic [TIME_W-1:0] r;
    logic p;
    rise = pv & ~prev_ff;
    fall = ~pv & prev_ff;
    q = quiet_ff;
    e = exp_ff;
    r = rem_ff;
    p = pre_ff;
    nxt_tick_cnt = tick ? '0 : tick_cnt_ff + TICK_W'(1);
    nxt_prev = prev_ff;
    nxt_nstart = nstart_ff;
    nxt_first = first_ff;
    nxt_bad = comb_bad;
    // a pending reset survives ticks skipped while an input is bad
    nxt_rst_pend = (sync_q[8] & ~rst_prev_ff) | sw_reset | (rst_pend_ff & ~(tick & ~comb_bad));
    if (tick && !comb_bad)
    begin
      q = 1'b0;
      nxt_prev = pv;
      nxt_first = 1'b0;
      if (rise)
        nxt_nstart = nstart_ff + 32'd1;
      unique case (ctrl_ff.timer_type)
        TT_MEASURE:
        begin
          p = pv;
          if (rise)
            e = '0;
          if (pv)
            e = inc(e);
          r = '0;
          q = ~pv;
        end
        TT_ACCUMULATE_ON_TIME:
        begin
          p = pv;
          if (pv)
            e = inc(e);
          r = '0;
        end
        TT_COMPARE, TT_DELAY:
        begin
          if (rise)
            e = '0;
          if (pv)
          begin
            e = inc(e);
            p = e >= sp_ff;
            r = p ? '0 : sp_ff - e;
          end
          else
          begin
            p = 1'b0;
            q = 1'b1;
          end
        end
        TT_EXTEND:
        begin
          if (fall)
            e = '0;
          if (!pv)
          begin
            e = inc(e);
            p = e < sp_ff;
            r = p ? sp_ff - e : '0;
          end
          else
          begin
            p = 1'b1;
            q = 1'b1;
          end
        end
        TT_DEBOUNCE:
        begin
          if (pv != prev_ff)
            e = '0;
          if (pv != pre_ff)
          begin
            e = inc(e);
            p = (e >= sp_ff) ? pv : pre_ff;
            r = (e >= sp_ff) ? '0 : sp_ff - e;
          end
          else
            q = 1'b1;
        end
        TT_PULSE, TT_RETRIGGERABLE_PULSE:
        begin
          if (rise && (!pre_ff || ctrl_ff.timer_type == TT_RETRIGGERABLE_PULSE))
          begin
            e = '0;
            p = 1'b1;
          end
          if (p)
          begin
            e = inc(e);
            p = e < sp_ff;
            r = p ? sp_ff - e : '0;
          end
          else
            q = ~pv;
        end
      endcase
      // idle behaviour, never for the accumulating type
      if (ctrl_ff.timer_type == TT_ACCUMULATE_ON_TIME)
        q = 1'b0;
      if (q && !ctrl_ff.idle_behaviour_option)
      begin
        e = '0;
        r = '0;
      end
      // first execution or timer reset reinitialises the timer
      if (first_ff || rst_pend_ff)
      begin
        e = '0;
        if (rst_pend_ff)
          nxt_nstart = 32'(rise);
        unique case (ctrl_ff.timer_type)
          TT_COMPARE, TT_DELAY:
          begin
            p = 1'b0;
            r = pv ? sp_ff : '0;
          end
          TT_EXTEND:
          begin
            p = 1'b1;
            r = pv ? '0 : sp_ff;
          end
          TT_PULSE, TT_RETRIGGERABLE_PULSE:
          begin
            p = 1'b0;
            r = '0;
          end
          default:
          begin
            p = pv;
            r = '0;
          end
        endcase
      end
    end
    nxt_pre = p;
    nxt_exp = e;
    nxt_rem = r;
    nxt_quiet = q;
    // output after mode selection and inversion
    nxt_out = (ctrl_ff.auto_mode ? pre_ff : ctrl_ff.manual_value)
              ^ incfg_ff.out_invert;
  end

  // timer register stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_ff <= '0;
      prev_ff <= 1'b0;
      pre_ff <= 1'b0;
      exp_ff <= '0;
      rem_ff <= '0;
      nstart_ff <= 32'h0000_0000;
      out_ff <= 1'b0;
      bad_ff <= 1'b0;
      quiet_ff <= 1'b0;
      first_ff <= 1'b1;
      rst_pend_ff <= 1'b0;
      rst_prev_ff <= 1'b0;
    end
    else
    begin
      tick_cnt_ff <= nxt_tick_cnt;
      prev_ff <= nxt_prev;
      pre_ff <= nxt_pre;
      exp_ff <= nxt_exp;
      rem_ff <= nxt_rem;
      nstart_ff <= nxt_nstart;
      out_ff <= nxt_out;
      bad_ff <= nxt_bad;
      quiet_ff <= nxt_quiet;
      first_ff <= nxt_first;
      rst_pend_ff <= nxt_rst_pend;
      rst_prev_ff <= sync_q[8];
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign out_d = out_ff;
  assign elapsed_time_output = exp_ff;
  assign remaining_time_output = rem_ff;
  assign bad_status = bad_ff;
endmodule

// File: discrete_timer_logic_bench.sv
// self-checking bench for the discrete timer logic block
// assumes the peer model and the port monitor beside it
`timescale 1ns/1ps
module discrete_timer_logic_bench;
  import timer_logic_pkg::*;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr, rerr, out_d, bad_status;
  logic timer_reset_in, want_reset;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] in_value, in_defined, want_value, want_defined;
  logic [15:0] elapsed, remaining;
  int failures = 0;
  int n_tests = 0;
  int c, p;
  always #5 clk = ~clk;
  discrete_timer_logic discrete_timer_logic_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_value(in_value), .in_defined(in_defined),
    .timer_reset_in(timer_reset_in), .out_d(out_d), .elapsed_time_output(elapsed),
    .remaining_time_output(remaining), .bad_status(bad_status));
  discrete_peers discrete_peers_i (.clk(clk), .rst_n(rst_n), .want_value(want_value),
    .want_defined(want_defined), .want_reset(want_reset), .in_value(in_value),
    .in_defined(in_defined), .timer_reset_in(timer_reset_in));
  // ****
  // tasks
  // ****
  // verdict and end of run
  task automatic complete_run;
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one bus transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic comb_exp(input int s, input int n);
    case (s)
      0: return n >= 1;
      1: return n >= 2;
      2: return n >= 3;
      3: return n == 4;
      4: return n == 1;
      5: return n == 2;
      6: return n == 3;
      7: return n % 2 == 0;
      default: return n % 2 == 1;
    endcase
  endfunction
  // ****
  // sequence
  // ****
  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, want_reset, want_value} = '0;
    want_defined = 4'hF;
    wt(5);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL, RST_CTRL);
    rd(OFF_INPUT_CFG, RST_INPUT_CFG);
    rd(OFF_SETPOINT, RST_SETPOINT);
    rd(OFF_TICK_LEN, 32'(RST_TICK_LEN));
    rd(8'h20, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, OFF_STATUS, 32'hFF);
    chk(rerr, 1'b0);
    apb(1'b1, OFF_TICK_LEN, 32'h1);
    for (c = 0; c < 9; c++)
    begin
      apb(1'b1, OFF_CTRL, {22'h0, c[3:0], 6'h01});
      for (p = 0; p < 16; p++)
      begin
        want_value <= p[3:0];
        wt(6);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rdata[ST_COMBINED], comb_exp(c, $countones(p[3:0])));
      end
    end
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_INPUT_CFG, 32'h0001_100F);
    want_value <= 4'h0;
    wt(6);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rdata[ST_COMBINED], 1'b1);
    chk(out_d, 1'b0);
    apb(1'b1, OFF_CTRL, 32'hC1);
    apb(1'b1, OFF_INPUT_CFG, 32'h0000_00E1);
    want_value <= 4'h1;
    wt(6);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rdata[ST_COMBINED], 1'b1);
    apb(1'b1, OFF_INPUT_CFG, 32'h0000_0E01);
    wt(6);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rdata[ST_COMBINED], 1'b0);
    apb(1'b1, OFF_INPUT_CFG, 32'hF);
    want_defined <= 4'hE;
    wt(6);
    chk(bad_status, 1'b1);
    want_defined <= 4'hF;
    wt(6);
    chk(bad_status, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h400);
    wt(4);
    chk(out_d, 1'b1);
    want_value <= 4'h0;
    apb(1'b1, OFF_CTRL, 32'h3);
    for (p = 0; p < 3; p++)
    begin
      want_value <= 4'h1;
      wt(20);
      chk(out_d, 1'b1);
      apb(1'b0, OFF_ELAPSED, 32'h0);
      chk(rdata != 0, 1'b1);
      want_value <= 4'h0;
      wt(6);
      chk(elapsed, 16'h0);
    end
    rd(OFF_START_COUNT, 32'h3);
    apb(1'b1, OFF_CTRL, 32'h5);
    want_value <= 4'h1;
    wt(20);
    want_value <= 4'h0;
    wt(6);
    chk(elapsed != 0, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h9);
    want_value <= 4'h1;
    wt(20);
    want_value <= 4'h0;
    wt(6);
    chk(elapsed != 0, 1'b1);
    want_reset <= 1'b1;
    wt(6);
    chk(elapsed, 16'h0);
    want_reset <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h19);
    want_value <= 4'h1;
    wt(8);
    chk(out_d, 1'b0);
    wt(20);
    chk(out_d, 1'b1);
    chk(remaining, 16'h0);
    want_value <= 4'h0;
    apb(1'b1, OFF_CTRL, 32'h31);
    want_value <= 4'h1;
    wt(6);
    chk(out_d, 1'b1);
    wt(20);
    chk(out_d, 1'b0);
    want_value <= 4'h0;
    wt(6);
    chk(elapsed, 16'h0);
    apb(1'b1, OFF_CTRL, 32'h29);
    want_value <= 4'h1;
    wt(30);
    chk(out_d, 1'b1);
    chk(elapsed, 16'h0);
    apb(1'b1, OFF_CTRL, 32'h21);
    want_value <= 4'h0;
    wt(6);
    chk(out_d, 1'b1);
    wt(20);
    chk(out_d, 1'b0);
    chk(remaining, 16'h0);
    apb(1'b1, OFF_CTRL, 32'h39);
    want_value <= 4'h1;
    wt(4);
    want_value <= 4'h0;
    wt(2);
    want_value <= 4'h1;
    wt(8);
    chk(out_d, 1'b1);
    wt(20);
    chk(out_d, 1'b0);
    complete_run;
  end
  // hang guard
  initial
  begin
    wt(40000);
    failures++;
    complete_run;
  end
endmodule

// File: discrete_timer_logic_monitor.sv
// port checks for the discrete timer logic block
// assumes a bind into each instance; one clock domain
`timescale 1ns/1ps
module discrete_timer_logic_monitor #(
  parameter int TIME_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] in_value,
  input wire logic [3:0] in_defined,
  input wire logic timer_reset_in,
  input wire logic out_d,
  input wire logic [TIME_W-1:0] elapsed_time_output,
  input wire logic [TIME_W-1:0] remaining_time_output,
  input wire logic bad_status
);
  logic [7:0] def_cnt_ff;
  logic [7:0] nxt_def_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // helper
  // ****
  // cycles with every input line defined, saturating
  always_comb
  begin
    nxt_def_cnt = def_cnt_ff;
    if (in_defined != 4'hF) nxt_def_cnt = 8'h00;
    else if (def_cnt_ff != 8'hFF) nxt_def_cnt = def_cnt_ff + 8'h01;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) def_cnt_ff <= 8'h00;
    else def_cnt_ff <= nxt_def_cnt;
  end
  // ****
  // properties
  // ****
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    pready ##1 !pready;
  endsequence
  property p_answer;
    s_access |=> s_done;
  endproperty
  property p_cause;
    pready |-> psel && penable && $past(psel && penable);
  endproperty
  property p_unmapped;
    pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0);
  endproperty
  property p_rd_err;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  property p_bad;
    def_cnt_ff >= 8'd120 |-> !bad_status;
  endproperty
  property p_elapsed;
    $changed(elapsed_time_output) |-> elapsed_time_output == $past(elapsed_time_output) + 1
      || elapsed_time_output <= 1 || remaining_time_output == 0;
  endproperty
  // while timing, elapsed plus remaining keeps the value it had one cycle before
  property p_remaining;
    $changed(remaining_time_output) && remaining_time_output != 0
      && $past(remaining_time_output) != 0 |->
      elapsed_time_output + remaining_time_output
      == $past(elapsed_time_output) + $past(remaining_time_output);
  endproperty
  property p_timer_reset;
    $rose(timer_reset_in) && !bad_status |-> ##[1:120] elapsed_time_output == 0;
  endproperty
  a_answer: assert property (p_answer) else $error("no single ready pulse");
  a_cause: assert property (p_cause) else $error("ready without access");
  a_unmapped: assert property (p_unmapped) else $error("wrong error response");
  a_rd_err: assert property (p_rd_err) else $error("refused read data not zero");
  a_bad: assert property (p_bad) else $error("bad status with all defined");
  a_elapsed: assert property (p_elapsed) else $error("elapsed step wrong");
  a_remaining: assert property (p_remaining) else $error("remaining step wrong");
  a_timer_reset: assert property (p_timer_reset) else $error("elapsed not cleared");
endmodule
bind discrete_timer_logic discrete_timer_logic_monitor #(.TIME_W(TIME_W)) monitor_i (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_value(in_value), .in_defined(in_defined), .timer_reset_in(timer_reset_in),
  .out_d(out_d), .elapsed_time_output(elapsed_time_output),
  .remaining_time_output(remaining_time_output), .bad_status(bad_status));

// File: input_combiner.sv
// merges up to four discrete inputs into one combined value
// assumes pin values are already synchronised to clk
`timescale 1ns/1ps
module input_combiner
  import timer_logic_pkg::*;
(
  input wire logic [3:0] in_value,
  input wire logic [3:0] in_defined,
  input timer_logic_pkg::in_cfg_s cfg,
  input timer_logic_pkg::comb_e sel,
  output logic combined,
  output logic bad
);
  logic [3:0] val;
  logic [3:0] used;
  logic [3:0] flt;
  logic [2:0] cnt;
  logic [2:0] n_used;

  // per-input selection and inversion
  for (genvar i = 0; i < NUM_INPUTS; i++)
  begin : g_in
    assign val[i] = (cfg.connected[i] ? in_value[i] : cfg.op_value[i])
                    ^ cfg.in_invert[i];
    assign used[i] = cfg.connected[i] | cfg.op_defined[i];
    assign flt[i] = cfg.connected[i] & ~in_defined[i];
  end

  // count true inputs and apply the combination
  always_comb
  begin
    cnt = '0;
    n_used = '0;
    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      cnt = cnt + 3'(val[i] & used[i]);
      n_used = n_used + 3'(used[i]);
    end
    bad = |flt;
    unique case (sel)
      COMB_OR: combined = cnt >= 3'd1;
      COMB_VOTE_TWO_OR_MORE: combined = cnt >= 3'd2;
      COMB_VOTE_THREE_OR_MORE: combined = cnt >= 3'd3;
      COMB_AND: combined = (cnt == n_used) && (n_used != 3'd0);
      COMB_COUNT_IS_ONE: combined = cnt == 3'd1;
      COMB_COUNT_IS_TWO: combined = cnt == 3'd2;
      COMB_COUNT_IS_THREE: combined = cnt == 3'd3;
      COMB_EVEN: combined = ~cnt[0];
      COMB_ODD: combined = cnt[0];
      default: combined = 1'b0;
    endcase
  end
endmodule

// File: timer_logic_pkg.sv
// constants, types and register layout of the discrete timer logic block
// assumes a 100 MHz clock and an APB register bus with 32-bit data
package timer_logic_pkg;

  // ************************************************************
  // clock and execution timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int EXEC_PERIOD_NS = 1000;
  localparam int EXEC_PERIOD_CYCLES = EXEC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 16;
  localparam int DEF_TIME_W = 16;
  localparam int NUM_INPUTS = 4;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INPUT_CFG = 8'h04;
  localparam logic [7:0] OFF_SETPOINT = 8'h08;
  localparam logic [7:0] OFF_TICK_LEN = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_ELAPSED = 8'h14;
  localparam logic [7:0] OFF_REMAINING = 8'h18;
  localparam logic [7:0] OFF_START_COUNT = 8'h1C;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] RST_CTRL = 32'h0000_0001;
  localparam logic [31:0] RST_INPUT_CFG = 32'h0000_000F;
  localparam logic [31:0] RST_SETPOINT = 32'h0000_000A;
  localparam logic [TICK_W-1:0] RST_TICK_LEN = TICK_W'(EXEC_PERIOD_CYCLES);

  // status bit positions
  localparam int ST_COMBINED = 0;
  localparam int ST_PRE_OUT = 1;
  localparam int ST_OUT = 2;
  localparam int ST_BAD = 3;
  localparam int ST_QUIESCENT = 4;

  // ************************************************************
  // enumerations
  // ************************************************************
  typedef enum logic [3:0] {
    COMB_OR, COMB_VOTE_TWO_OR_MORE, COMB_VOTE_THREE_OR_MORE, COMB_AND,
    COMB_COUNT_IS_ONE, COMB_COUNT_IS_TWO, COMB_COUNT_IS_THREE,
    COMB_EVEN, COMB_ODD
  } comb_e;

  typedef enum logic [2:0] {
    TT_MEASURE, TT_ACCUMULATE_ON_TIME, TT_COMPARE, TT_DELAY,
    TT_EXTEND, TT_DEBOUNCE, TT_PULSE, TT_RETRIGGERABLE_PULSE
  } timer_e;

  // ************************************************************
  // register layouts
  // ************************************************************
  typedef struct packed {
    logic [20:0] rsvd;
    logic manual_value;
    comb_e combination_select;
    timer_e timer_type;
    logic idle_behaviour_option; // 0 clear, 1 keep last
    logic timer_reset;
    logic auto_mode;
  } ctrl_s;

  typedef struct packed {
    logic [14:0] rsvd;
    logic out_invert;
    logic [3:0] in_invert;
    logic [3:0] op_defined;
    logic [3:0] op_value;
    logic [3:0] connected;
  } in_cfg_s;

endpackage
